// ===== design/rtcal_consts.vh
// Register offsets, field positions and reset values for the RTC alarm block
`ifndef RTCAL_CONSTS_VH
`define RTCAL_CONSTS_VH

`define RTCAL_ADDR_W            4
`define RTCAL_OFS_SECOND_ALARM  4'h0
`define RTCAL_OFS_MINUTE_ALARM  4'h1
`define RTCAL_OFS_HOUR_ALARM    4'h2
`define RTCAL_OFS_WEEKDAY_ALARM 4'h3
`define RTCAL_OFS_DATE_ALARM    4'h4
`define RTCAL_OFS_MONTH_ALARM   4'h5
`define RTCAL_OFS_FLAG_CTRL     4'h6
`define RTCAL_NUM_ALARMS        6

`define RTCAL_BIT_CMP_EN        7
`define RTCAL_BIT_CARRY_FLAG    7
`define RTCAL_BIT_CARRY_IE      4
`define RTCAL_BIT_ALARM_IE      3
`define RTCAL_BIT_ALARM_FLAG    0

`define RTCAL_MASK_SECOND       8'h7f
`define RTCAL_MASK_MINUTE       8'h7f
`define RTCAL_MASK_HOUR         8'h3f
`define RTCAL_MASK_WEEKDAY      8'h07
`define RTCAL_MASK_DATE         8'h3f
`define RTCAL_MASK_MONTH        8'h1f
`define RTCAL_MASK_FLAG_CTRL    8'h99
`define RTCAL_FLAG_CTRL_RESET   8'h00
`define RTCAL_UNMAPPED_DATA     32'h00000000

`endif

// ===== design/rtcal_alarm_mem.v
// Alarm value store without reset, registered read port
`timescale 1ns/1ps
`include "rtcal_consts.vh"

module rtcal_alarm_mem #(
  parameter DEPTH = `RTCAL_NUM_ALARMS,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             wrEn,
  input  wire [AW-1:0]    wrAddr,
  input  wire [6:0]       wrData,
  input  wire [AW-1:0]    rdAddr,
  output reg  [6:0]       rdData,
  output wire [7*DEPTH-1:0] allData
);

  // Value fields survive every reset, so no reset term here
  reg [6:0] mem [0:DEPTH-1];
  genvar g;

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gFlat
      assign allData[7*g +: 7] = mem[g];
    end
  endgenerate

endmodule // rtcal_alarm_mem

// ===== design/rtcal_match.v
// Enabled-field comparison and first-match edge detect
`timescale 1ns/1ps
`include "rtcal_consts.vh"

module rtcal_match (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [5:0]  cmpEnable,
  input  wire [41:0] alarmValues,
  input  wire [41:0] counterValues,
  output wire        matchNow,
  output wire        matchRise
);

  reg  [5:0] fieldHit;
  reg        matchPrev_r;
  integer    i;

  function [7:0] fieldMask;
    input integer idx;
    begin
      case (idx)
        0:       fieldMask = `RTCAL_MASK_SECOND;
        1:       fieldMask = `RTCAL_MASK_MINUTE;
        2:       fieldMask = `RTCAL_MASK_HOUR;
        3:       fieldMask = `RTCAL_MASK_WEEKDAY;
        4:       fieldMask = `RTCAL_MASK_DATE;
        default: fieldMask = `RTCAL_MASK_MONTH;
      endcase
    end
  endfunction

  always @* begin
    fieldHit = 6'h00;
    for (i = 0; i < 6; i = i + 1) begin
      // Disabled fields count as hit; only enabled ones are compared
      fieldHit[i] = ~cmpEnable[i] |
        ((alarmValues[7*i +: 7] & fieldMask(i)) ==
         (counterValues[7*i +: 7] & fieldMask(i)));
    end
  end

  // Nothing enabled never matches
  assign matchNow = (&fieldHit) & (|cmpEnable);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      matchPrev_r <= 1'b0;
    end else begin
      matchPrev_r <= matchNow;
    end
  end

  // Flag once per match window, not every cycle of it
  assign matchRise = matchNow & ~matchPrev_r;

endmodule // rtcal_match

// ===== design/rtcal_top.v
// RTC alarm comparison, carry/alarm flags and interrupt requests on Avalon-MM
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rtcal_consts.vh"

// Summary of operation
// - Compare only fields whose bit 7 enable is set; alarm when all enabled agree.
// - Hour alarm is BCD 00 to 23; bit 6 reads zero.
// - Weekday alarm holds code 0 to 6 in bits 2..0; bits 6..3 read zero, bit 7 reads its enable.
// - Enable bits clear on power-on only; values survive all resets and standby.
// - Control register zero on power-on; manual reset keeps carry flag; standby holds.
// - Carry flag sets on every sub-second or second counter increment.
// - Writing 0 to carry flag clears it.
// - Carry interrupt asserted while carry flag and its enable are both 1.
// - Alarm interrupt asserted while alarm flag and its enable are both 1.
// - Alarm flag sets when time matches every enabled alarm field.
// - Writing 0 clears alarm flag; writing 1 leaves it unchanged.
// - Reserved control bits 6, 5, 2, 1 read zero.
// - Second alarm joins the comparison; its enable clears on power-on.
module rtcal_top (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        manualRstn,
  input  wire        standby,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [7:0]  second_counter,
  input  wire [7:0]  minute_counter,
  input  wire [7:0]  hour_counter,
  input  wire [7:0]  weekday_counter,
  input  wire [7:0]  date_counter,
  input  wire [7:0]  month_counter,
  input  wire        subSecondTick,
  input  wire        secondTick,
  output wire        carryIrq,
  output wire        alarmIrq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_DONE  = 2'd2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [5:0]  cmpEnable_r;
  reg         carryFlag_r;
  reg         carryIrqEn_r;
  reg         alarmIrqEn_r;
  reg         alarmFlag_r;
  reg  [3:0]  rdAddr_r;
  reg         manualDone_r;
  wire [6:0]  memRdData;
  wire [41:0] alarmValues;
  wire [41:0] counterValues;
  wire        matchRise;
  wire        lane0;
  wire        isAlarm;
  wire        wrAlarm;
  wire        wrCtrl;
  wire        carryEvent;
  wire [2:0]  memWrAddr;
  wire [2:0]  memRdAddr;
  wire [7:0]  ctrlRead;
  wire [7:0]  rdMasked;

  function isAlarmAddr;
    input [3:0] a;
    begin
      isAlarmAddr = (a <= `RTCAL_OFS_MONTH_ALARM);
    end
  endfunction

  function [7:0] readMask;
    input [3:0] a;
    begin
      if (a == `RTCAL_OFS_SECOND_ALARM) begin
        readMask = `RTCAL_MASK_SECOND;
      end else if (a == `RTCAL_OFS_MINUTE_ALARM) begin
        readMask = `RTCAL_MASK_MINUTE;
      end else if (a == `RTCAL_OFS_HOUR_ALARM) begin
        readMask = `RTCAL_MASK_HOUR;
      end else if (a == `RTCAL_OFS_WEEKDAY_ALARM) begin
        readMask = `RTCAL_MASK_WEEKDAY;
      end else if (a == `RTCAL_OFS_DATE_ALARM) begin
        readMask = `RTCAL_MASK_DATE;
      end else begin
        readMask = `RTCAL_MASK_MONTH;
      end
    end
  endfunction

  // Writes finish in the first cycle; reads take three for the registered memory
  assign avs_waitrequest = avs_read ? (state_r != ST_DONE) : 1'b0;

  assign lane0     = avs_byteenable[0];
  assign isAlarm   = isAlarmAddr(avs_address);
  assign wrAlarm   = avs_write & lane0 & isAlarm;
  assign wrCtrl    = avs_write & lane0 & (avs_address == `RTCAL_OFS_FLAG_CTRL);
  assign memWrAddr = avs_address[2:0];
  assign memRdAddr = avs_address[2:0];

  assign counterValues = {month_counter[6:0], date_counter[6:0], weekday_counter[6:0],
                          hour_counter[6:0], minute_counter[6:0], second_counter[6:0]};

  rtcal_alarm_mem #(
    .DEPTH (`RTCAL_NUM_ALARMS),
    .AW    (3)
  ) uMem (
    .sys_clk (sys_clk),
    .wrEn    (wrAlarm),
    .wrAddr  (memWrAddr),
    .wrData  (avs_writedata[6:0]),
    .rdAddr  (memRdAddr),
    .rdData  (memRdData),
    .allData (alarmValues)
  );

  rtcal_match uMatch (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .cmpEnable     (cmpEnable_r),
    .alarmValues   (alarmValues),
    .counterValues (counterValues),
    .matchNow      (),
    .matchRise     (matchRise)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (avs_read) state_nxt = ST_FETCH;
      ST_FETCH: state_nxt = ST_DONE;
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      rdAddr_r <= 4'h0;
    end else begin
      state_r  <= state_nxt;
      rdAddr_r <= avs_address;
    end
  end

  assign rdMasked = {1'b0, memRdData} & readMask(rdAddr_r);

  assign ctrlRead = {carryFlag_r, 2'b00, carryIrqEn_r, alarmIrqEn_r,
                     2'b00, alarmFlag_r};

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= `RTCAL_UNMAPPED_DATA;
    end else if (state_r == ST_FETCH) begin
      if (isAlarmAddr(rdAddr_r)) begin
        avs_readdata <= {24'h000000,
          cmpEnable_r[rdAddr_r[2:0]], rdMasked[6:0]};
      end else if (rdAddr_r == `RTCAL_OFS_FLAG_CTRL) begin
        avs_readdata <= {24'h000000, ctrlRead & `RTCAL_MASK_FLAG_CTRL};
      end else begin
        avs_readdata <= `RTCAL_UNMAPPED_DATA;
      end
    end
  end

  // Enables cleared by power-on reset only; manual reset and standby keep them
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmpEnable_r <= 6'h00;
    end else if (wrAlarm) begin
      cmpEnable_r[memWrAddr] <= avs_writedata[`RTCAL_BIT_CMP_EN];
    end
  end

  assign carryEvent = subSecondTick | secondTick;

  // Manual reset is level-sampled; clears every cycle it is held low, carry flag untouched
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      carryFlag_r  <= 1'b0;
      carryIrqEn_r <= 1'b0;
      alarmIrqEn_r <= 1'b0;
      alarmFlag_r  <= 1'b0;
      manualDone_r <= 1'b0;
    end else begin
      manualDone_r <= ~manualRstn;
      if (carryEvent) begin
        carryFlag_r <= 1'b1;
      end else if (wrCtrl && !avs_writedata[`RTCAL_BIT_CARRY_FLAG]) begin
        carryFlag_r <= 1'b0;
      end
      if (!manualRstn) begin
        carryIrqEn_r <= 1'b0;
        alarmIrqEn_r <= 1'b0;
        alarmFlag_r  <= 1'b0;
      end else begin
        if (wrCtrl) begin
          carryIrqEn_r <= avs_writedata[`RTCAL_BIT_CARRY_IE];
          alarmIrqEn_r <= avs_writedata[`RTCAL_BIT_ALARM_IE];
        end
        if (matchRise) begin
          alarmFlag_r <= 1'b1;
        end else if (wrCtrl && !avs_writedata[`RTCAL_BIT_ALARM_FLAG]) begin
          alarmFlag_r <= 1'b0;
        end
      end
    end
  end

  assign carryIrq = carryFlag_r & carryIrqEn_r;
  assign alarmIrq = alarmFlag_r & alarmIrqEn_r;

endmodule // rtcal_top

// ===== test/rtcal_assertions.sv
// Port-level checks for the RTC alarm and flag block
`timescale 1ns/1ps
module rtcal_assertions (
  input wire        sys_clk,
  input wire        rstn,
  input wire        manualRstn,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        subSecondTick,
  input wire        secondTick,
  input wire        carryIrq,
  input wire        alarmIrq
);
  // Shadow of both irq enables, since the checker sees no register state
  reg  [1:0] ie_r;
  wire       ctlWr = avs_write && avs_byteenable[0] && avs_address == 4'h6;
  wire       tick  = subSecondTick || secondTick;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ie_r <= 2'b00;
    else if (!manualRstn) ie_r <= 2'b00;
    else if (ctlWr) ie_r <= avs_writedata[4:3];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ctl_reserved: assert property (
    avs_read && !avs_waitrequest && avs_address == 4'h6 |=> (avs_readdata & 32'hffffff66) == 0)
    else $error("reserved control bits not zero");
  a_tick_carry: assert property (tick && ie_r[1] && !ctlWr && manualRstn |=> carryIrq)
    else $error("tick did not raise carry irq");
  a_carry_gate: assert property (carryIrq |-> ie_r[1])
    else $error("carry irq without enable");
  a_alarm_gate: assert property (alarmIrq |-> ie_r[0])
    else $error("alarm irq without enable");
  a_carry_hold: assert property (carryIrq && !ctlWr && manualRstn |=> carryIrq)
    else $error("carry irq dropped without clear");
  a_alarm_hold: assert property (alarmIrq && !ctlWr && manualRstn |=> alarmIrq)
    else $error("alarm irq dropped without clear");
  a_manual_quiet: assert property (!manualRstn |=> !carryIrq && !alarmIrq)
    else $error("irq after manual reset");
  a_carry_clear: assert property (
    ctlWr && !avs_writedata[7] && !tick && manualRstn |=> !carryIrq)
    else $error("carry irq after zero write");
endmodule // rtcal_assertions

bind rtcal_top rtcal_assertions i_rtcal_assertions (.sys_clk(sys_clk), .rstn(rstn),
  .manualRstn(manualRstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .subSecondTick(subSecondTick), .secondTick(secondTick), .carryIrq(carryIrq),
  .alarmIrq(alarmIrq));

// ===== test/rtcal_cal_model.sv
// Calendar counters and increment ticks of the neighbouring counter unit
`timescale 1ns/1ps
module rtcal_cal_model (
  input  wire        sys_clk,
  output reg  [47:0] calendar = 48'h01_01_00_00_00_00,
  output reg         subSecondTick = 1'b0,
  output reg         secondTick = 1'b0
);
  // Counters move only on an edge, holding whatever value the bench sets
  task setCal(input [47:0] v);
    begin
      @(posedge sys_clk);
      calendar <= v;
      // Alarm flag lands one edge after the match shows
      @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
  // One-cycle increment pulse of either counter
  task pulse(input sec);
    begin
      @(posedge sys_clk);
      subSecondTick <= !sec;
      secondTick <= sec;
      @(posedge sys_clk);
      subSecondTick <= 1'b0;
      secondTick <= 1'b0;
      @(negedge sys_clk);
    end
  endtask
endmodule // rtcal_cal_model

// ===== test/rtcal_top_test.sv
// Self-checking bench for the RTC alarm compare and flag block
`timescale 1ns/1ps
module rtcal_top_test;
  reg         sys_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         manualRstn = 1'b1;
  reg         standby = 1'b0;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [47:0] cal;
  wire        subTick;
  wire        secTick;
  wire        carryIrq;
  wire        alarmIrq;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i;
  reg  [47:0] masks = 48'h1f_3f_07_3f_7f_7f;
  reg  [47:0] alm = 48'h12_31_06_23_45_30;
  reg  [31:0] q = 32'h0;
  always #50 sys_clk = ~sys_clk;
  rtcal_cal_model i_rtcal_cal_model (.sys_clk(sys_clk), .calendar(cal),
    .subSecondTick(subTick), .secondTick(secTick));
  rtcal_top i_rtcal_top (.sys_clk(sys_clk), .rstn(rstn), .manualRstn(manualRstn),
    .standby(standby), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .second_counter(cal[7:0]), .minute_counter(cal[15:8]), .hour_counter(cal[23:16]),
    .weekday_counter(cal[31:24]), .date_counter(cal[39:32]), .month_counter(cal[47:40]),
    .subSecondTick(subTick), .secondTick(secTick), .carryIrq(carryIrq), .alarmIrq(alarmIrq));
  task cmp(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task irq(input [1:0] e);
    cmp({30'h0, carryIrq, alarmIrq}, {30'h0, e});
  endtask
  // Holds the request until an edge samples waitrequest low; read data taken there
  task bus(input w, input [3:0] a, input [7:0] d, input b, output [31:0] r);
    integer n;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {4{d}};
      avs_byteenable <= {3'h7, b};
      if (w) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 50) n_errors = n_errors + 1;
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Flags launched by this edge are looked at once settled
      @(negedge sys_clk);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    bus(1'b1, a, d, 1'b1, q);
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00, 1'b1, q);
      cmp(q, {24'h0, e});
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatched %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(4'h6, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      wr(i[3:0], 8'hff);
      rd(i[3:0], 8'h80 | masks[i*8 +: 8]);
    end
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) rd(i[3:0], masks[i*8 +: 8]);
    $display("test reset values done");
    i_rtcal_cal_model.setCal(48'h12_31_06_23_44_30);
    wr(4'h6, 8'h08);
    for (i = 0; i < 6; i = i + 1) wr(i[3:0], alm[i*8 +: 8] | ((i == 1 || i == 2) ? 8'h80 : 8'h00));
    irq(2'b00);
    i_rtcal_cal_model.setCal(48'h12_31_06_22_45_30);
    irq(2'b00);
    // Counter bit 7 set everywhere: only bits 6..0 take part
    i_rtcal_cal_model.setCal(alm | 48'h80_80_80_80_80_80);
    irq(2'b01);
    i_rtcal_cal_model.setCal(48'h12_31_06_23_46_30);
    irq(2'b01);
    i_rtcal_cal_model.setCal(alm);
    wr(4'h6, 8'h09);
    irq(2'b01);
    wr(4'h6, 8'h08);
    irq(2'b00);
    rd(4'h6, 8'h08);
    i_rtcal_cal_model.setCal(48'h12_31_06_23_46_30);
    wr(4'h6, 8'h00);
    i_rtcal_cal_model.setCal(alm);
    irq(2'b00);
    rd(4'h6, 8'h01);
    for (i = 0; i < 6; i = i + 1) wr(i[3:0], alm[i*8 +: 8]);
    wr(4'h6, 8'h08);
    i_rtcal_cal_model.setCal(48'h12_31_06_23_46_30);
    i_rtcal_cal_model.setCal(alm);
    rd(4'h6, 8'h08);
    $display("test alarm done");
    wr(4'h6, 8'h10);
    i_rtcal_cal_model.pulse(1'b0);
    irq(2'b10);
    wr(4'h6, 8'h10);
    irq(2'b00);
    i_rtcal_cal_model.pulse(1'b1);
    rd(4'h6, 8'h90);
    wr(4'h6, 8'h80);
    irq(2'b00);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h98);
    bus(1'b1, 4'h6, 8'h00, 1'b0, q);
    rd(4'h9, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h6, 8'h98);
    $display("test carry done");
    wr(4'h1, 8'hc5);
    @(posedge sys_clk);
    standby <= 1'b1;
    manualRstn <= 1'b0;
    @(posedge sys_clk);
    manualRstn <= 1'b1;
    rd(4'h6, 8'h80);
    rd(4'h1, 8'hc5);
    $display("test manual reset done");
    results;
  end
endmodule // rtcal_top_test
